// >>> hdl/rae_pkg.sv
// What this block does
// - Reactive power: shifted current times voltage, filtered
// - Accumulate reactive power over whole half cycles
// - Half cycle count is unsigned 16-bit
// - Period end sets the cycle end flag
// - Enabled cycle end flag pulls interrupt low
// - Integrator on gives -90, off gives +90
// - Reactive sign independent of integrator setting
// - Apparent power is current rms times voltage rms
// - Apparent gain is one plus gain over 4096
// - Gain 0x7ff about +50, 0x800 about -50
// - No separate apparent power offset correction
// - Apparent power summed in 49-bit accumulator
// - One accumulation every four clock cycles
// - Apparent accumulation uses signed addition
// - Divide by 8-bit divider, zero acts as one
// - Upper 24 quotient bits form apparent energy
// - Second apparent energy copy clears on read
// - Interrupt on apparent half full or overflow
// - Half cycles counted at voltage zero crossings
// - Cycle end flag sits at status bit 2
`default_nettype none
package rae_pkg;
    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFS_APPARENT_GAIN   = 8'h00;
    localparam logic [7:0] OFS_APPARENT_DIV    = 8'h04;
    localparam logic [7:0] OFS_HALF_CYCLES     = 8'h08;
    localparam logic [7:0] OFS_APPARENT_ENERGY = 8'h0c;
    localparam logic [7:0] OFS_APPARENT_RC     = 8'h10;
    localparam logic [7:0] OFS_LINE_REACTIVE   = 8'h14;
    localparam logic [7:0] OFS_MODE            = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS      = 8'h1c;
    localparam logic [7:0] OFS_IRQ_ENABLE      = 8'h20;
    localparam logic [7:0] OFS_REACTIVE_POWER  = 8'h24;
    // Field positions
    localparam int BIT_HALF_FULL  = 0;
    localparam int BIT_OVERFLOW   = 1;
    localparam int BIT_CYCLE_END  = 2;
    localparam int BIT_INTEG_EN   = 0;
    localparam int IRQ_BITS       = 3;
    // Reset values
    localparam logic [11:0] RST_APPARENT_GAIN = 12'h000;
    localparam logic [7:0]  RST_APPARENT_DIV  = 8'h00;
    localparam logic [15:0] RST_HALF_CYCLES   = 16'hffff;
    localparam logic [2:0]  RST_IRQ_ENABLE    = 3'h0;
    localparam logic        RST_INTEG_EN      = 1'b0;
    // Timing: master clocks per accumulation sample
    localparam int SAMPLE_CLKS = 4;
    // Apparent gain fraction bits
    localparam int GAIN_FRAC = 12;
endpackage : rae_pkg
`default_nettype wire

// >>> hdl/rae_phase_shift.sv
`default_nettype none
// Quadrature filter for the current channel
module rae_phase_shift #(
    parameter int W    = 16,   // Sample width
    parameter int LEAK = 6     // Leak shift of the integrating branch
) (
    input  wire logic                ref_clk_i,
    input  wire logic                rst_n_i,
    input  wire logic                smp_stb_i,
    input  wire logic                int_en_i,
    input  wire logic signed [W-1:0] sample_i,
    output logic signed [W-1:0]      shifted_o
);
    logic signed [W-1:0] prev_r;     // Last sample, for the difference branch
    logic signed [W+7:0] integ_r;    // Leaky running sum, lags by 90 degrees
    logic signed [W:0]   diff;       // First difference, leads by 90 degrees
    logic signed [W+7:0] integ_nxt;

    assign diff      = (W+1)'(sample_i) - (W+1)'(prev_r);
    // Leak keeps the sum from walking away on a residual dc offset
    assign integ_nxt = integ_r + (W+8)'(sample_i) - (integ_r >>> LEAK);

    // Both branches advance on the sample strobe
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_r  <= '0;
            integ_r <= '0;
        end else if (smp_stb_i) begin
            prev_r  <= sample_i;
            integ_r <= integ_nxt;
        end
    end

    // Integrator on picks the lagging branch
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shifted_o <= '0;
        end else if (smp_stb_i) begin
            shifted_o <= int_en_i ? integ_r[W+7:8] : diff[W:1];
        end
    end
endmodule : rae_phase_shift
`default_nettype wire

// >>> hdl/rae_apparent_accum.sv
`default_nettype none
// Apparent power, gain, 49-bit accumulation and division
module rae_apparent_accum #(
    parameter int RW = 24,   // Rms value width
    parameter int AW = 49    // Internal accumulator width
) (
    input  wire logic           ref_clk_i,
    input  wire logic           rst_n_i,
    input  wire logic           smp_stb_i,
    input  wire logic [RW-1:0]  cur_rms_i,
    input  wire logic [RW-1:0]  volt_rms_i,
    input  wire logic [11:0]    gain_i,
    input  wire logic [7:0]     divider_i,
    input  wire logic           rc_clear_i,
    output logic [23:0]         energy_o,
    output logic [23:0]         energy_rc_o
);
    logic [2*RW-1:0]      prod;      // Full rms product
    logic signed [RW:0]   power;     // Apparent power, upper product half
    logic signed [RW+12:0] gain_term; // Power times signed gain
    logic signed [RW+1:0] power_g;   // Gain corrected power
    logic signed [AW-1:0] add_term;  // Sign extended addend
    logic signed [AW-1:0] acc_r;     // Main accumulator
    logic signed [AW-1:0] acc_rc_r;  // Read-clear accumulator
    logic [7:0]           div_eff;   // Zero divider acts as one
    logic [AW-1:0]        quot;
    logic [AW-1:0]        quot_rc;

    // Rms product; offsets already removed upstream
    assign prod      = cur_rms_i * volt_rms_i;
    assign power     = {1'b0, prod[2*RW-1:RW]};
    // Scale by one plus gain over 4096
    assign gain_term = power * $signed(gain_i);
    assign power_g   = (RW+2)'(power) + (RW+2)'(gain_term >>> rae_pkg::GAIN_FRAC);
    assign add_term  = AW'(power_g);
    assign div_eff   = (divider_i == 8'h00) ? 8'h01 : divider_i;
    assign quot      = $unsigned(acc_r) / div_eff;
    assign quot_rc   = $unsigned(acc_rc_r) / div_eff;

    // Signed accumulation on every sample strobe
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_r <= '0;
        end else if (smp_stb_i) begin
            acc_r <= acc_r + add_term;
        end
    end

    // Read-clear copy; a sample landing on the clear cycle is kept
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_rc_r <= '0;
        end else if (rc_clear_i) begin
            acc_rc_r <= smp_stb_i ? add_term : '0;
        end else if (smp_stb_i) begin
            acc_rc_r <= acc_rc_r + add_term;
        end
    end

    // Registered upper quotient bits
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            energy_o    <= '0;
            energy_rc_o <= '0;
        end else begin
            energy_o    <= quot[AW-1:AW-24];
            energy_rc_o <= rc_clear_i ? 24'h000000 : quot_rc[AW-1:AW-24];
        end
    end
endmodule : rae_apparent_accum
`default_nettype wire

// >>> hdl/rae_top.sv
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`default_nettype none
// Reactive and apparent energy accumulation with a Wishbone slave
module rae_top #(
    parameter int SW      = 16,  // Channel sample width
    parameter int RW      = 24,  // Rms value width
    parameter int LPF_SH  = 8,   // Reactive low-pass shift
    parameter int LVAR_W  = 48   // Line reactive accumulator width
) (
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_n_i,
    // Wishbone classic slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [31:0]          wb_dat_i,
    input  wire logic [3:0]           wb_sel_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    // Upstream samples and rms values, same clock
    input  wire logic signed [SW-1:0] cur_sample_i,
    input  wire logic signed [SW-1:0] volt_sample_i,
    input  wire logic [RW-1:0]        cur_rms_i,
    input  wire logic [RW-1:0]        volt_rms_i,
    // Open-drain interrupt: output level and enable
    output logic                      irq_n_o,
    output logic                      irq_n_oe_o
);
    // Reset release synchroniser
    logic rst_meta_r;
    logic rst_sync_r;
    logic rst_n;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    assign rst_n = rst_sync_r;

    // Sample strobe, one cycle in every four
    logic [1:0] smp_cnt_r;
    logic       smp_stb;

    assign smp_stb = (smp_cnt_r == 2'(rae_pkg::SAMPLE_CLKS - 1));

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            smp_cnt_r <= '0;
        end else begin
            smp_cnt_r <= smp_cnt_r + 2'd1;
        end
    end

    // Software visible state
    logic [11:0]        gain_r;        // apparent_gain
    logic [7:0]         div_r;         // apparent_energy_divider
    logic [15:0]        half_cycle_count_r;
    logic               integ_en_r;    // Current channel integrator on
    logic [2:0]         irq_en_r;      // Interrupt enables
    logic [2:0]         irq_stat_r;    // Sticky event flags
    logic [2:0]         irq_stat_nxt;
    logic [2:0]         irq_set;
    logic [2:0]         irq_clr;

    // Bus decode
    logic        bus_req;       // New request, ack not yet given
    logic        wr_take;       // Write taken this edge
    logic        rd_take;       // Read taken this edge
    logic [31:0] wmask;         // Byte lanes expanded to bits
    logic [31:0] wdata_m;       // Masked write data
    logic        sel_gain;
    logic        sel_div;
    logic        sel_half;
    logic        sel_mode;
    logic        sel_stat;
    logic        sel_en;
    logic        sel_rc;
    logic [31:0] rd_mux;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_take = bus_req && wb_we_i;
    assign rd_take = bus_req && !wb_we_i;
    assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wdata_m = wb_dat_i & wmask;

    assign sel_gain = (wb_adr_i == rae_pkg::OFS_APPARENT_GAIN);
    assign sel_div  = (wb_adr_i == rae_pkg::OFS_APPARENT_DIV);
    assign sel_half = (wb_adr_i == rae_pkg::OFS_HALF_CYCLES);
    assign sel_mode = (wb_adr_i == rae_pkg::OFS_MODE);
    assign sel_stat = (wb_adr_i == rae_pkg::OFS_IRQ_STATUS);
    assign sel_en   = (wb_adr_i == rae_pkg::OFS_IRQ_ENABLE);
    assign sel_rc   = (wb_adr_i == rae_pkg::OFS_APPARENT_RC);

    // Quadrature current and reactive power
    logic signed [SW-1:0]     cur_shift;
    logic signed [2*SW-1:0]   rprod;       // Instantaneous reactive power
    logic signed [2*SW:0]     rprod_s;     // Sign corrected
    logic signed [2*SW:0]     lpf_r;       // Filtered reactive power
    logic signed [2*SW+1:0]   lpf_step;
    logic signed [LVAR_W-1:0] lvar_acc_r;  // Running reactive sum
    logic signed [LVAR_W-1:0] lvar_add;
    logic [23:0]              line_reactive_energy_r;

    rae_phase_shift #(
        .W         (SW),
        .LEAK      (6)
    ) u_shift (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n),
        .smp_stb_i (smp_stb),
        .int_en_i  (integ_en_r),
        .sample_i  (cur_sample_i),
        .shifted_o (cur_shift)
    );

    assign rprod    = cur_shift * volt_sample_i;
    // A lagging shift flips the product, so it is turned back here
    assign rprod_s  = integ_en_r ? -(2*SW+1)'(rprod) : (2*SW+1)'(rprod);
    assign lpf_step = (2*SW+2)'(rprod_s) - (2*SW+2)'(lpf_r);
    assign lvar_add = LVAR_W'(lpf_r);

    // First-order low-pass keeps the dc term
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            lpf_r <= '0;
        end else if (smp_stb) begin
            lpf_r <= lpf_r + (2*SW+1)'(lpf_step >>> LPF_SH);
        end
    end

    // Voltage sign zero crossings
    logic        vsign_r;
    logic        zx;
    logic [15:0] half_cnt_r;
    logic        period_end;

    assign zx         = smp_stb && (volt_sample_i[SW-1] != vsign_r);
    // A zero count ends every half cycle rather than never
    assign period_end = zx && ((half_cnt_r + 16'd1) >= half_cycle_count_r);

    // Half cycle counter and line reactive accumulation
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            vsign_r                <= 1'b0;
            half_cnt_r             <= '0;
            lvar_acc_r             <= '0;
            line_reactive_energy_r <= '0;
        end else if (smp_stb) begin
            vsign_r <= volt_sample_i[SW-1];
            if (period_end) begin
                // Latch the period, restart with this sample
                line_reactive_energy_r <= lvar_acc_r[LVAR_W-1:LVAR_W-24];
                lvar_acc_r             <= lvar_add;
                half_cnt_r             <= '0;
            end else begin
                lvar_acc_r <= lvar_acc_r + lvar_add;
                if (zx) begin
                    half_cnt_r <= half_cnt_r + 16'd1;
                end
            end
        end
    end

    // Apparent energy path
    logic [23:0] app_energy;
    logic [23:0] app_energy_rc;
    logic [23:0] app_prev_r;     // Last apparent energy, for event detection
    logic        half_full_ev;
    logic        overflow_ev;

    rae_apparent_accum #(
        .RW          (RW),
        .AW          (49)
    ) u_app (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n),
        .smp_stb_i   (smp_stb),
        .cur_rms_i   (cur_rms_i),
        .volt_rms_i  (volt_rms_i),
        .gain_i      (gain_r),
        .divider_i   (div_r),
        .rc_clear_i  (rd_take && sel_rc),
        .energy_o    (app_energy),
        .energy_rc_o (app_energy_rc)
    );

    // Half full is bit 23 rising, overflow a wrap
    assign half_full_ev = app_energy[23] && !app_prev_r[23];
    assign overflow_ev  = app_energy < app_prev_r;

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            app_prev_r <= '0;
        end else begin
            app_prev_r <= app_energy;
        end
    end

    // Event flags: set wins over a write-one clear in the same cycle
    assign irq_set = {smp_stb && period_end, overflow_ev, half_full_ev};
    assign irq_clr = (wr_take && sel_stat) ? wdata_m[2:0] : 3'h0;
    assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // Pin driven low while an enabled flag stands
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_n_o    <= 1'b1;
            irq_n_oe_o <= 1'b0;
        end else begin
            irq_n_o    <= 1'b0;
            irq_n_oe_o <= |(irq_stat_nxt & irq_en_r);
        end
    end

    // Control registers, byte lanes honoured
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            gain_r             <= rae_pkg::RST_APPARENT_GAIN;
            div_r              <= rae_pkg::RST_APPARENT_DIV;
            half_cycle_count_r <= rae_pkg::RST_HALF_CYCLES;
            integ_en_r         <= rae_pkg::RST_INTEG_EN;
            irq_en_r           <= rae_pkg::RST_IRQ_ENABLE;
        end else if (wr_take) begin
            if (sel_gain) begin
                gain_r <= (gain_r & ~wmask[11:0]) | wdata_m[11:0];
            end
            if (sel_div) begin
                div_r <= (div_r & ~wmask[7:0]) | wdata_m[7:0];
            end
            if (sel_half) begin
                half_cycle_count_r <= (half_cycle_count_r & ~wmask[15:0])
                                      | wdata_m[15:0];
            end
            if (sel_mode && wb_sel_i[0]) begin
                integ_en_r <= wb_dat_i[rae_pkg::BIT_INTEG_EN];
            end
            if (sel_en && wb_sel_i[0]) begin
                irq_en_r <= wb_dat_i[2:0];
            end
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h00000000;
        unique case (wb_adr_i)
            rae_pkg::OFS_APPARENT_GAIN:   rd_mux = {20'h00000, gain_r};
            rae_pkg::OFS_APPARENT_DIV:    rd_mux = {24'h000000, div_r};
            rae_pkg::OFS_HALF_CYCLES:     rd_mux = {16'h0000, half_cycle_count_r};
            rae_pkg::OFS_APPARENT_ENERGY: rd_mux = {8'h00, app_energy};
            rae_pkg::OFS_APPARENT_RC:     rd_mux = {8'h00, app_energy_rc};
            rae_pkg::OFS_LINE_REACTIVE:   rd_mux = {{8{line_reactive_energy_r[23]}},
                                                    line_reactive_energy_r};
            rae_pkg::OFS_MODE:            rd_mux = {31'h00000000, integ_en_r};
            rae_pkg::OFS_IRQ_STATUS:      rd_mux = {29'h00000000, irq_stat_r};
            rae_pkg::OFS_IRQ_ENABLE:      rd_mux = {29'h00000000, irq_en_r};
            rae_pkg::OFS_REACTIVE_POWER:  rd_mux = lpf_r[2*SW:1];
            default:                      rd_mux = 32'h00000000;
        endcase
    end

    // Ack one cycle after the request
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req;
            if (rd_take) begin
                wb_dat_o <= rd_mux;
            end
        end
    end
endmodule : rae_top
`default_nettype wire

// >>> test/rae_checker.sv
`default_nettype none
// Port checks of rae_top
module rae_checker (
    input wire logic        ref_clk_i,
    input wire logic        rst_n_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        irq_n_o,
    input wire logic        irq_n_oe_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Request taken, and its read kind
    wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic rd  = req && !wb_we_i;
    property p_ack_next; req |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_rd_hold; !rd |=> $stable(wb_dat_o); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_unmapped; wb_ack_o && $past(rd) && $past(wb_adr_i) >= 8'h28 |-> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_gain_w; wb_ack_o && $past(rd) && $past(wb_adr_i) == rae_pkg::OFS_APPARENT_GAIN
        |-> wb_dat_o[31:12] == 20'h0; endproperty
    a_gain_w: assert property (p_gain_w) else $error("gain wider than 12 bits");
    property p_cyc_w; wb_ack_o && $past(rd) && $past(wb_adr_i) == rae_pkg::OFS_HALF_CYCLES
        |-> wb_dat_o[31:16] == 16'h0; endproperty
    a_cyc_w: assert property (p_cyc_w) else $error("count wider than 16 bits");
    property p_energy_w; wb_ack_o && $past(rd) && ($past(wb_adr_i) == rae_pkg::OFS_APPARENT_RC
        || $past(wb_adr_i) == rae_pkg::OFS_APPARENT_ENERGY) |-> wb_dat_o[31:24] == 8'h0;
    endproperty
    a_energy_w: assert property (p_energy_w) else $error("energy wider than 24");
    property p_irq_lvl; irq_n_oe_o |-> !irq_n_o; endproperty
    a_irq_lvl: assert property (p_irq_lvl) else $error("irq not low");
    property p_en_gate; wb_ack_o && !$past(rd) && $past(wb_adr_i) == rae_pkg::OFS_IRQ_ENABLE
        && $past(wb_sel_i[0]) && $past(wb_dat_i[2:0]) == 3'h0 |=> !irq_n_oe_o; endproperty
    a_en_gate: assert property (p_en_gate) else $error("irq while masked");
    // Scenarios
    c_irq: cover property (irq_n_oe_o);
    c_end: cover property (wb_ack_o && $past(wb_adr_i) == rae_pkg::OFS_IRQ_STATUS && wb_dat_o[2]);
    c_unmapped: cover property (wb_ack_o && $past(rd) && $past(wb_adr_i) >= 8'h28);
endmodule : rae_checker
bind rae_top rae_checker i_rae_checker (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_n_o(irq_n_o), .irq_n_oe_o(irq_n_oe_o));
`default_nettype wire

// >>> test/rae_upstream_model.sv
`default_nettype none
// Sine channels, voltage leading by lag_i samples
module rae_upstream_model #(
    parameter int P = 32  // Samples per line cycle
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic signed [7:0] lag_i,
    output logic signed [15:0]     cur_o,
    output logic signed [15:0]     volt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned n_r;  // Clock count
    // Half-sample offset keeps both half cycles equally long
    function automatic logic signed [15:0] wave(int k);
        return 16'(int'($sin(6.2831853 * (real'(k) + 0.5) / P) * 12000.0));
    endfunction : wave
    // New sample every fourth clock, one per strobe
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            n_r    <= 0;
            cur_o  <= '0;
            volt_o <= '0;
        end else begin
            n_r <= n_r + 1;
            if (n_r[1:0] == 2'h0) begin
                cur_o  <= wave(int'(n_r >> 2));
                volt_o <= wave(int'(n_r >> 2) + int'(lag_i));
            end
        end
    end
endmodule : rae_upstream_model
`default_nettype wire

// >>> test/rae_tb_top.sv
`default_nettype none
// Bench of rae_top
module rae_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic               ref_clk_i = 1'b0, rst_n_i = 1'b0;
    logic               cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]         adr = 8'h00;
    logic [31:0]        wdat = 32'h0, rdat, dat_o;
    logic [3:0]         sel = 4'h0;
    logic [23:0]        irms = 24'h0, vrms = 24'h0;
    logic signed [7:0]  lag = 8'sh04;
    logic signed [15:0] cur_s, volt_s;
    logic               ack, irq_n, irq_oe;
    int                 err_total = 0, comparisons = 0, cyc_cnt = 0;
    // Pin level with its pull-up
    wire logic irq_wire = irq_oe ? irq_n : 1'b1;
    logic [7:0] ofs[5] = '{rae_pkg::OFS_APPARENT_GAIN, rae_pkg::OFS_APPARENT_DIV,
        rae_pkg::OFS_HALF_CYCLES, rae_pkg::OFS_MODE, rae_pkg::OFS_IRQ_ENABLE};
    logic [31:0] rstv[5] = '{32'h0, 32'h0, 32'hffff, 32'h0, 32'h0};
    logic [31:0] msk[5] = '{32'hfff, 32'hff, 32'hffff, 32'h1, 32'h7};
    rae_top i_rae_top (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .cur_sample_i(cur_s), .volt_sample_i(volt_s),
        .cur_rms_i(irms), .volt_rms_i(vrms), .irq_n_o(irq_n), .irq_n_oe_o(irq_oe));
    rae_upstream_model i_rae_upstream_model (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .lag_i(lag), .cur_o(cur_s), .volt_o(volt_s));
    always #20 ref_clk_i = ~ref_clk_i;
    // Hang guard
    always @(posedge ref_clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 90000) begin
            err_total++;
            close_out();
        end
    end
    task automatic close_out();
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    // An unknown never matches
    task automatic chk(input logic [31:0] got, input real exp, input real tol);
        comparisons++;
        if ($isunknown(got) || real'(got) > exp + tol || real'(got) < exp - tol) begin
            err_total++;
            $display("ERROR %0t: got %0d expected %0f", $time, got, exp);
        end
    endtask : chk
    // Held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, d, 4'hf};
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rdat = dat_o;
        {cyc, stb} <= 2'b00;
        if (n >= 50) begin
            err_total++;
            $display("ERROR %0t: no bus answer", $time);
        end
    endtask : wb
    task automatic rd(input logic [7:0] a);
        wb(1'b0, a, 32'h0);
    endtask : rd
    // Poll for the period end flag
    task automatic wait_end();
        int n;
        n = 0;
        do begin
            rd(rae_pkg::OFS_IRQ_STATUS);
            n++;
        end while (rdat[2] !== 1'b1 && n < 500);
        chk(32'(rdat[2]), 1.0, 0.0);
    endtask : wait_end
    // Energy LSBs added per sample
    function automatic real step(logic [23:0] i, logic [23:0] v, logic [11:0] g, logic [7:0] d);
        real p;
        p = real'((48'(i) * 48'(v)) >> 24) * (4096.0 + real'($signed(g))) / 4096.0;
        return p / real'(d == 8'h0 ? 8'h1 : d) / 33554432.0;
    endfunction : step
    initial begin
        logic [11:0] g;
        logic [7:0]  d;
        logic [23:0] e0;
        int          t0;
        real         st;
        real         x;
        void'($urandom(32'h6e889082));
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        // Reset values, then writable widths
        for (int i = 0; i < 5; i++) begin
            rd(ofs[i]);
            chk(rdat, real'(rstv[i]), 0.0);
            wb(1'b1, ofs[i], 32'hffffffff);
            rd(ofs[i]);
            chk(rdat, real'(msk[i]), 0.0);
        end
        wb(1'b1, 8'h28, 32'hffffffff);
        rd(8'h28);
        chk(rdat, 0.0, 0.0);
        // Periods of 0, 1 and 3 half cycles, masked
        wb(1'b1, rae_pkg::OFS_IRQ_ENABLE, 32'h0);
        for (int k = 0; k < 3; k++) begin
            wb(1'b1, rae_pkg::OFS_HALF_CYCLES, 32'(k + k / 2));
            wb(1'b1, rae_pkg::OFS_IRQ_STATUS, 32'h4);
            wait_end();
            t0 = cyc_cnt;
            wb(1'b1, rae_pkg::OFS_IRQ_STATUS, 32'h4);
            rd(rae_pkg::OFS_IRQ_STATUS);
            chk(32'(rdat[2]), 0.0, 0.0);
            wait_end();
            chk(32'(cyc_cnt - t0), 64.0 * (k == 0 ? 1 : k + k / 2), 8.0);
        end
        chk(32'(irq_wire), 1.0, 0.0);
        wb(1'b1, rae_pkg::OFS_IRQ_ENABLE, 32'h4);
        @(posedge ref_clk_i);
        chk(32'(irq_wire), 0.0, 0.0);
        wb(1'b1, rae_pkg::OFS_IRQ_ENABLE, 32'h0);
        // Reactive sign, lead and lag, integrator off and on
        for (int m = 0; m < 4; m++) begin
            lag <= (m % 2) ? -8'sd4 : 8'sd4;
            wb(1'b1, rae_pkg::OFS_MODE, 32'(m / 2));
            repeat (6000) @(posedge ref_clk_i);
            rd(rae_pkg::OFS_REACTIVE_POWER);
            chk(32'(rdat[31]), real'(m % 2), 0.0);
            rd(rae_pkg::OFS_LINE_REACTIVE);
            chk(32'(rdat[23]), real'(m % 2), 0.0);
        end
        // Apparent energy: corners, then random
        for (int t = 0; t < 6; t++) begin
            g = (t == 1) ? 12'h7ff : (t == 2) ? 12'h800 : (t == 0) ? 12'h0 : 12'($urandom);
            d = (t < 3) ? 8'(t) : 8'($urandom_range(3));
            irms <= 24'h800000 | 24'($urandom);
            vrms <= 24'h800000 | 24'($urandom);
            wb(1'b1, rae_pkg::OFS_APPARENT_GAIN, 32'(g));
            wb(1'b1, rae_pkg::OFS_APPARENT_DIV, 32'(d));
            repeat (20) @(posedge ref_clk_i);
            rd(rae_pkg::OFS_APPARENT_ENERGY);
            e0 = rdat[23:0];
            t0 = cyc_cnt;
            rd(rae_pkg::OFS_APPARENT_RC);
            repeat (2400) @(posedge ref_clk_i);
            rd(rae_pkg::OFS_APPARENT_ENERGY);
            st = step(irms, vrms, g, d);
            x = st * (cyc_cnt - t0) / 4.0;
            chk(32'(rdat[23:0] - e0), x, 3.0 * st + 2.0);
            rd(rae_pkg::OFS_APPARENT_RC);
            chk(32'(rdat[23:0]), x, 3.0 * st + 2.0);
            rd(rae_pkg::OFS_APPARENT_RC);
            chk(32'(rdat[23:0]), 0.0, 2.0 * st + 2.0);
        end
        close_out();
    end
endmodule : rae_tb_top
`default_nettype wire
